//--- src/bhh_top.sv
// Purpose: bus hold arbitration and shared port pins of the memory bus
// Assumes: bus controller reports quiet and pending; pins are asynchronous
// Notes:   every output is a flop; pin inputs use three-stage filtering
`timescale 1ns/1ps
module bhh_top
  import bhh_pkg::*;
(
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  input  wire logic [7:0]           window_select_reg,
  input  wire logic [7:0]           reg_addr,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  input  wire logic [7:0]           reg_wdata,
  output logic      [7:0]           reg_rdata,
  input  wire logic [BHH_NPINS-1:0] pad_in,
  output bhh_pad_t                  pad,
  input  wire logic                 bus_quiet,
  input  wire logic                 cycle_pending,
  output logic                      bus_released,
  output logic                      hold_mode
);

  ////////////////////////////////////////////////////////////////////////
  // pin input filtering
  logic [BHH_NPINS-1:0] sync1_r, sync2_r, sync3_r, pin_lvl_r;
  logic [BHH_NPINS-1:0] pin_lvl_nxt;

  // a change counts only when stages two and three agree
  always_comb begin
    for (int i = 0; i < BHH_NPINS; i++) begin
      pin_lvl_nxt[i] = (sync2_r[i] == sync3_r[i]) ? sync3_r[i] : pin_lvl_r[i];
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      sync1_r   <= '1;
      sync2_r   <= '1;
      sync3_r   <= '1;
      pin_lvl_r <= '1;
    end else begin
      sync1_r   <= pad_in;
      sync2_r   <= sync1_r;
      sync3_r   <= sync2_r;
      pin_lvl_r <= pin_lvl_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode select and port register
  logic                 mode_hold;
  logic                 port_hit;
  logic [BHH_NPINS-1:0] latch_r, latch_nxt;
  logic [7:0]           rdata_r, rdata_nxt;
  logic                 mode_r, mode_nxt;

  assign mode_hold = window_select_reg[BHH_MODE_BIT];
  assign port_hit  = (window_select_reg[BHH_WIN_LSB +: BHH_WIN_W] == BHH_PORT_WIN[6:0])
                   && (reg_addr == BHH_PORT_ADDR);

  // latches take port writes in hold mode too; the pads only follow them in port mode
  always_comb begin
    latch_nxt = latch_r;
    rdata_nxt = rdata_r;
    mode_nxt  = mode_hold;
    if (port_hit && reg_wr) begin
      latch_nxt = reg_wdata[BHH_PIN_LSB +: BHH_NPINS];
    end
    if (port_hit && reg_rd) begin
      rdata_nxt = 8'h00;
      rdata_nxt[BHH_PIN_LSB +: BHH_NPINS] = pin_lvl_r;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      latch_r <= BHH_LATCH_RST;
      rdata_r <= BHH_RDATA_RST;
      mode_r  <= 1'b0;
    end else begin
      latch_r <= latch_nxt;
      rdata_r <= rdata_nxt;
      mode_r  <= mode_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // hold handshake state machine
  bhh_state_t state_r, state_nxt;
  logic       take_req;
  logic       ack_r, ack_nxt;
  logic       pend_r, pend_nxt;
  logic       rel_r, rel_nxt;

  // takeover only seen while the pin is in hold mode
  assign take_req = mode_hold && !pin_lvl_r[BHH_PIN_HOLD];

  always_comb begin
    state_nxt = state_r;
    ack_nxt   = ack_r;
    pend_nxt  = pend_r;
    rel_nxt   = rel_r;
    case (state_r)
      // bus goes back to the controller one cycle after both pins read high
      BHH_IDLE: begin
        rel_nxt = 1'b0;
        if (take_req) state_nxt = BHH_DRAIN;
      end
      // finish the running cycle before letting go
      BHH_DRAIN: begin
        if (!take_req) begin
          state_nxt = BHH_IDLE;
        end else if (bus_quiet) begin
          state_nxt = BHH_FLOAT;
          rel_nxt   = 1'b1;
        end
      end
      // bus is floated one cycle before ack_r sets, two before the acknowledge pin goes low
      BHH_FLOAT: begin
        state_nxt = BHH_HELD;
        ack_nxt   = 1'b1;
      end
      BHH_HELD: begin
        // no new request once the takeover is gone, avoids a stray low pulse
        if (cycle_pending && take_req) pend_nxt = 1'b1;
        if (!take_req) begin
          state_nxt = BHH_UNACK;
          ack_nxt   = 1'b0;
        end
      end
      BHH_UNACK: begin
        state_nxt = BHH_RESUME;
        pend_nxt  = 1'b0;
      end
      // pending pin rises on the next edge; the bus stays floated meanwhile
      BHH_RESUME: begin
        state_nxt = BHH_IDLE;
      end
      default: begin
        state_nxt = BHH_IDLE;
        ack_nxt   = 1'b0;
        pend_nxt  = 1'b0;
        rel_nxt   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_r <= BHH_IDLE;
      ack_r   <= 1'b0;
      pend_r  <= 1'b0;
      rel_r   <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ack_r   <= ack_nxt;
      pend_r  <= pend_nxt;
      rel_r   <= rel_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // pad drive
  bhh_pad_t pad_r, pad_nxt;

  // quasi-bidirectional modelled as open drain in port mode: only a low is driven; hold mode drives pend and ack both ways
  always_comb begin
    pad_nxt = '{out: '0, oe: '0};
    if (mode_hold) begin
      pad_nxt.out[BHH_PIN_PEND] = !pend_r;
      pad_nxt.out[BHH_PIN_ACK]  = !ack_r;
      pad_nxt.oe[BHH_PIN_PEND]  = 1'b1;
      pad_nxt.oe[BHH_PIN_ACK]   = 1'b1;
    end else begin
      pad_nxt.oe = ~latch_r;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      pad_r <= '{out: '0, oe: '0};
    end else begin
      pad_r <= pad_nxt;
    end
  end

  assign pad          = pad_r;
  assign reg_rdata    = rdata_r;
  assign bus_released = rel_r;
  assign hold_mode    = mode_r;

  ////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  a_port_mode_pins: assert property (!mode_hold |=> pad.oe == ~$past(latch_r) && pad.out == '0)
    else $error("port mode drives a pin whose latch is high");
  a_hold_mode_pins: assert property (mode_hold |=> pad.oe[BHH_PIN_PEND] && pad.oe[BHH_PIN_ACK]
                                     && !pad.oe[BHH_PIN_HOLD])
    else $error("hold mode pin directions wrong");
  a_port_write_low: assert property (port_hit && reg_wr && !reg_wdata[BHH_PIN_LSB] && !mode_hold
                                     ##1 !mode_hold |=> pad.oe[BHH_PIN_PEND])
    else $error("port write of zero did not pull pin low");
  a_ack_after_float: assert property ($rose(ack_r) |-> $past(rel_r) && rel_r)
    else $error("acknowledge before bus released");
  a_pend_on_cycle: assert property (state_r == BHH_HELD && cycle_pending && take_req |=> pend_r)
    else $error("pending request missed");
  a_pend_needs_ack: assert property ($rose(pend_r) |-> $past(ack_r))
    else $error("pending request before acknowledge");
  a_pend_holds_on: assert property (pend_r && take_req |=> pend_r)
    else $error("pending request dropped while takeover held");
  a_release_order: assert property ($fell(ack_r) |-> rel_r ##1 !pend_r && rel_r
                                    ##1 rel_r ##1 !rel_r)
    else $error("release sequence out of order");

  c_full_hold:   cover property ($rose(ack_r) ##[1:50] $fell(ack_r));
  c_pend_seen:   cover property ($rose(pend_r) ##[1:50] $fell(pend_r));
  c_drain_abort: cover property (state_r == BHH_DRAIN ##1 state_r == BHH_IDLE);
  c_port_read:   cover property (port_hit && reg_rd && !mode_hold);

endmodule

//--- src/bhh_pkg.sv
// Purpose: constants and types for the bus hold handshake block
// Assumes: 200 MHz ref_clk, one clock domain, no software bus
// Notes:   pins are active low on the wire; port mode is open drain
//
// What this block does
// - window bit 7 clear: pins are port bits
// - window bit 7 set: pins carry hold signals
// - port mode quasi-bidirectional, register 0fh, window 0
// - acknowledge low only after bus released
// - during hold, request low when cycle waits
// - pending request waits for acknowledge first
// - pending request stays low until takeover released
package bhh_pkg;

  localparam int unsigned BHH_NPINS      = 3;
  localparam logic [7:0]  BHH_PORT_ADDR  = 8'h0f;  // port register location
  localparam logic [7:0]  BHH_PORT_WIN   = 8'h00;  // hardware register window
  localparam int unsigned BHH_MODE_BIT   = 7;      // window select bit for pin mode
  localparam int unsigned BHH_PIN_LSB    = 5;      // first shared bit of the port
  localparam int unsigned BHH_WIN_LSB    = 0;      // window number field lsb
  localparam int unsigned BHH_WIN_W      = 7;      // window number field width
  localparam logic [2:0]  BHH_LATCH_RST  = 3'h7;   // port latches reset high (released)
  localparam logic [7:0]  BHH_RDATA_RST  = 8'h00;

  // pin positions inside the shared group
  localparam int unsigned BHH_PIN_PEND = 0;  // port_one_bit5 / pending_cycle_request
  localparam int unsigned BHH_PIN_ACK  = 1;  // port_one_bit6 / bus_release_ack
  localparam int unsigned BHH_PIN_HOLD = 2;  // port_one_bit7 / takeover request in

  // hold handshake states, one-hot
  typedef enum logic [5:0] {
    BHH_IDLE    = 6'h01,
    BHH_DRAIN   = 6'h02,
    BHH_FLOAT   = 6'h04,
    BHH_HELD    = 6'h08,
    BHH_UNACK   = 6'h10,
    BHH_RESUME  = 6'h20
  } bhh_state_t;

  // pad drive bundle for the three shared pins
  typedef struct packed {
    logic [BHH_NPINS-1:0] out;
    logic [BHH_NPINS-1:0] oe;
  } bhh_pad_t;

endpackage

//--- dv/bhh_master_model.sv
// Purpose: external bus master that asks for the memory bus
// Assumes: pin levels are resolved by the bench
// Notes:   owns the bus only while the acknowledge shows low
`timescale 1ns/1ps
module bhh_master_model (
  input  wire logic       ref_clk,
  input  wire logic       reset,
  input  wire logic       want,
  input  wire logic [2:0] pin_lvl,
  output logic            take_n,
  output logic            granted
);
  // request pin moves only just after a clock edge
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset)
      take_n <= 1'b1;
    else
      take_n <= ~want;
  end
  // no bus use before the device has let go
  assign granted = ~take_n & ~pin_lvl[1];
endmodule

//--- dv/tb_top.sv
// Purpose: self-checking bench for the bus hold handshake
// Assumes: pull-ups on pins 0 and 1, master model on the takeover pin
// Notes:   inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module tb_top;
  import bhh_pkg::*;
  logic       ref_clk = 1'b0, reset = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic       bus_quiet = 1'b0, cycle_pending = 1'b0, want = 1'b0;
  logic [7:0] window_select_reg = 8'h00, reg_addr = 8'h0f, reg_wdata = 8'h00;
  logic [7:0] reg_rdata;
  logic [2:0] pin_lvl;
  bhh_pad_t   pad;
  logic       bus_released, hold_mode, take_n, granted;
  int         errors = 0, samples_checked = 0, n;
  always #2.5 ref_clk = ~ref_clk;
  // wire level: own driver, else master on pin 2, else pull-up
  assign pin_lvl = (pad.oe & pad.out) | (~pad.oe & {take_n, 2'b11});
  bhh_top bhh_top_inst (.ref_clk(ref_clk), .reset(reset),
    .window_select_reg(window_select_reg), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pad_in(pin_lvl),
    .pad(pad), .bus_quiet(bus_quiet), .cycle_pending(cycle_pending),
    .bus_released(bus_released), .hold_mode(hold_mode));
  bhh_master_model bhh_master_model_inst (.ref_clk(ref_clk), .reset(reset),
    .want(want), .pin_lvl(pin_lvl), .take_n(take_n), .granted(granted));
  ////////////////////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge ref_clk);
    #1;
  endtask
  // one-cycle strobes, data held until the strobe drops
  task automatic wr(input logic [7:0] d);
    reg_wdata = d;
    reg_wr = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [7:0] exp);
    reg_rd = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    tick(1);
    chk(reg_rdata, exp);
  endtask
  // bounded wait on a pin level; a hang ends the run
  task automatic wait_pin(input int idx, input logic lvl);
    for (n = 0; n < 40 && pin_lvl[idx] !== lvl; n++)
      tick(1);
    if (n == 40) begin
      errors++;
      final_report();
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_port();
    wr(8'h00);
    tick(2);
    chk({4'h0, pad.oe, hold_mode}, 8'h0e);
    tick(4);
    rd(8'h00);
    wr(8'ha0);
    tick(6);
    rd(8'ha0);
    reg_addr = 8'h0e;  // wrong address is ignored
    wr(8'h00);
    reg_addr = 8'h0f;
    window_select_reg = 8'h01;  // wrong window is ignored
    wr(8'h00);
    window_select_reg = 8'h00;
    tick(2);
    chk({5'h0, pad.oe}, 8'h02);
    wr(8'he0);
    want = 1'b1;  // takeover must be ignored in port mode
    tick(12);
    chk({6'h0, pad.oe[1:0]} | {7'h0, bus_released}, 8'h00);
    want = 1'b0;
    tick(6);
    $display("port test done");
  endtask
  task automatic t_hold();
    window_select_reg = 8'h80;
    cycle_pending = 1'b1;
    tick(3);
    chk({4'h0, hold_mode, pin_lvl}, 8'h0f);
    want = 1'b1;
    tick(12);
    chk({4'h0, granted, bus_released, pin_lvl[1:0]}, 8'h03);
    bus_quiet = 1'b1;
    wait_pin(1, 1'b0);
    chk({6'h0, granted, bus_released}, 8'h03);
    wait_pin(0, 1'b0);
    chk({6'h0, pin_lvl[1:0]}, 8'h00);
    cycle_pending = 1'b0;
    tick(5);
    chk({7'h0, pin_lvl[0]}, 8'h00);
    want = 1'b0;
    wait_pin(1, 1'b1);
    chk({6'h0, pin_lvl[0], bus_released}, 8'h01);
    wait_pin(0, 1'b1);
    chk({7'h0, bus_released}, 8'h01);
    tick(1);
    chk({7'h0, bus_released}, 8'h00);
    $display("hold test done");
  endtask
  // takeover withdrawn while draining, then a hold with nothing waiting
  task automatic t_abort();
    bus_quiet = 1'b0;
    want = 1'b1;
    tick(12);
    chk({4'h0, granted, bus_released, pin_lvl[1:0]}, 8'h03);
    want = 1'b0;
    tick(8);
    bus_quiet = 1'b1;
    tick(8);
    chk({5'h0, bus_released, pin_lvl[1:0]}, 8'h03);
    want = 1'b1;
    wait_pin(1, 1'b0);
    tick(4);
    chk({6'h0, granted, pin_lvl[0]}, 8'h03);
    want = 1'b0;
    wait_pin(1, 1'b1);
    tick(3);
    chk({6'h0, bus_released, pin_lvl[0]}, 8'h01);
    $display("abort test done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    tick(16);
    reset = 1'b0;
    tick(1);
    t_port();
    t_hold();
    t_abort();
    final_report();
  end
endmodule
